// ==== core/scope_cmd_map.svh ====
// constants of the bus command interpreter: offsets, characters, fields
// assumes it is included by the interpreter itself; its package does not include it
`ifndef SCOPE_CMD_MAP_SVH
`define SCOPE_CMD_MAP_SVH
// ************
// wishbone register offsets and bits
// ************
`define OFS_CTRL 4'h0
`define OFS_STATUS 4'h4
`define OFS_ADDR 4'h8
`define CTRL_EN_BIT 0
`define STAT_SRQ_BIT 0
`define CTRL_RST 1'b1
// ************
// ascii characters seen on the bus
// ************
`define CH_ZERO 8'h30
`define CH_EIGHT 8'h38
`define CH_SPACE 8'h20
`define CH_MINUS 8'h2d
`define CH_CR 8'h0d
`define CH_LF 8'h0a
`define CH_H 8'h48
`define CH_R 8'h52
`define CH_S 8'h53
`define CH_T 8'h54
`define CH_D 8'h44
`define CH_N 8'h4e
// ************
// field sizes, limits and positions
// ************
`define ASCII_LEN 3'h5
`define BIN_LEN 3'h2
`define NORM_LEN 27
`define NORM_SETS 8
`define POS_HFLAG 5'h01
`define POS_MFRAC 5'h02
`define POS_VZSIGN 5'h03
`define POS_VZLAST 5'h07
`define DATA_MAX 16'sh07ff
`define DATA_MIN 16'shf800
`define TRACK_MAX 4'h8
`define AUTO_ARG 4'h3
`define MEM_ALL 3'h6
`define MEM_HALF 3'h4
`define POW_THOU 12'h3e8
`define POW_HUND 12'h064
`define POW_TEN 12'h00a
`endif

// ==== core/scope_cmd_pkg.sv ====
// types shared by the bus command interpreter
// assumes the constant header sits beside it
package scope_cmd_pkg;
  // sequencer states, one-hot
  typedef enum logic [2:0] {
    S_IDLE = 3'h1,
    S_RD = 3'h2,
    S_CONV = 3'h4
  } state_t;
  // transfer modes selected by data and normalization commands
  typedef enum logic [3:0] {
    ASCII_AUTO_ADVANCE = 4'h0,
    ASCII_LOAD_ADDR = 4'h1,
    BINARY_AUTO_ADVANCE = 4'h2,
    BINARY_LOAD_ADDR = 4'h3,
    STATUS_REPORT = 4'h4,
    NORM_BOTH = 4'h8,
    NORM_STANDARD = 4'h9,
    NORM_RESET = 4'ha
  } mode_t;
  // disk recorder operations
  typedef enum logic [1:0] {
    OP_RECALL = 2'h0,
    OP_STORE = 2'h1,
    OP_SEEK = 2'h2,
    OP_AUTO = 2'h3
  } disk_op_t;
endpackage : scope_cmd_pkg

// ==== core/scope_bus_command_set.sv ====
// bus command interpreter: disk commands, waveform and normalization transfer
// assumes a listener/talker front end on clk_i handing over bytes, a waveform
// memory answering one cycle after a read strobe, panel levels from outside
//
// Design decisions made here: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
`include "scope_cmd_map.svh"
module scope_bus_command_set
  import scope_cmd_pkg::*;
#(
  parameter int unsigned ADDR_W = 12, // waveform address width
  parameter int unsigned NSETS = `NORM_SETS // normalization sets per kind
) (
  input logic clk_i,
  input logic rst_i,
  input logic ce_i, // low freezes all state
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [3:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input logic cmd_valid_i, // byte at command listen address
  input logic [7:0] cmd_data_i,
  input logic din_valid_i, // byte at data listen address
  input logic [7:0] din_data_i,
  output logic din_ready_o,
  input logic talk_i, // addressed as talker
  output logic dout_valid_o,
  output logic [7:0] dout_data_o,
  input logic dout_ready_i,
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [15:0] mem_wdata_o,
  input logic [15:0] mem_rdata_i,
  input logic [3:0] panel_track_i,
  input logic [2:0] panel_mem_i,
  input logic panel_auto_i,
  input logic panel_reset_used_i,
  input logic ext_adv_i,
  input logic [1:0] channels_i,
  input logic disk_done_i,
  output logic disk_go_o,
  output logic [1:0] disk_op_o,
  output logic [3:0] disk_track_o,
  output logic srq_o
);
  // ************
  // parameters and state
  // ************
  localparam int unsigned NB = NSETS * `NORM_LEN; // bytes per kind
  localparam int unsigned PW = 13; // synchronised pin bits

  if (ADDR_W < 12 || ADDR_W > 16 || NSETS < 1 || NSETS > 8) begin : g_bad_param
    $error("unsupported ADDR_W or NSETS");
  end

  typedef struct packed {
    logic [PW-1:0] s1; // first sync stage, read by s2 only
    logic [PW-1:0] s2; // second sync stage
    logic done_d; // done level one cycle late
    state_t st;
    mode_t mode;
    logic en; // software enable of the command decoder
    logic [7:0] lead; // command letter awaiting its digit
    logic lead_v;
    logic ld_asc; // last command was ascii load address, no data byte since
    logic ld_bin; // last command was binary load address, no data byte since
    logic [ADDR_W-1:0] addr; // internal address counter
    logic neg;
    logic [15:0] acc; // field being assembled
    logic [2:0] fcnt;
    logic [39:0] tx; // reply bytes, first in top
    logic [2:0] txn;
    logic [7:0] dout;
    logic dv;
    logic rdy;
    logic [11:0] cv; // magnitude left to convert
    logic [1:0] ck; // decimal place
    logic [3:0] dig;
    logic [ADDR_W-1:0] maddr;
    logic mre;
    logic mwe;
    logic [15:0] mwd;
    disk_op_t dop;
    logic dgo;
    logic [3:0] dtrk;
    logic pend; // disk job whose end raises a request
    logic srq;
    logic [2:0] nset;
    logic [4:0] npos;
    logic [NB-1:0][7:0] nstd; // standard normalization sets
    logic [NB-1:0][7:0] nrst; // reset normalization sets
    logic ack;
    logic [31:0] rdat;
  } regs_t;

  regs_t r_reg;
  regs_t r_next;

  // synchronised panel and disk levels
  logic done_s, ext_s, rstu_s, auto_s;
  logic [1:0] chan_s;
  logic [2:0] mem_s;
  logic [3:0] trk_s;
  assign {done_s, ext_s, rstu_s, auto_s, chan_s, mem_s, trk_s} = r_reg.s2;

  // ************
  // helpers
  // ************
  // clamp a sample to the 12-bit signed range
  function automatic logic [15:0] sat(input logic [15:0] v);
    if ($signed(v) > $signed(`DATA_MAX)) begin
      sat = `DATA_MAX;
    end else if ($signed(v) < $signed(`DATA_MIN)) begin
      sat = `DATA_MIN;
    end else begin
      sat = v;
    end
  endfunction : sat

  // weight of a decimal place
  function automatic logic [11:0] pw(input logic [1:0] k);
    case (k)
      2'h0: pw = `POW_THOU;
      2'h1: pw = `POW_HUND;
      default: pw = `POW_TEN;
    endcase
  endfunction : pw

  // next character position, wrapping after the last set
  function automatic logic [7:0] nstep(input logic [2:0] s, input logic [4:0] p);
    if (p != 5'(`NORM_LEN - 1)) begin
      nstep = {s, p + 5'h01};
    end else if (s == 3'(NSETS - 1)) begin
      nstep = 8'h00;
    end else begin
      nstep = {s + 3'h1, 5'h00};
    end
  endfunction : nstep

  // ************
  // next state
  // ************
  always_comb begin
    logic [7:0] b;
    logic [3:0] n;
    logic [15:0] v;
    logic [15:0] mag;
    logic [7:0] nb;
    logic [7:0] idx;
    logic [3:0] frac;
    logic fin;
    b = 8'h00;
    n = 4'h0;
    v = 16'h0000;
    mag = 16'h0000;
    nb = 8'h00;
    fin = 1'b0;
    idx = 8'(r_reg.nset * `NORM_LEN + r_reg.npos);
    // multiplier by memory range, full 1, halves 2, quarters 4
    frac = (mem_s == `MEM_ALL) ? 4'h1 : (mem_s >= `MEM_HALF) ? 4'h2 : 4'h4;
    frac = 4'(frac * chan_s);
    r_next = r_reg;
    r_next.s1 = {disk_done_i, ext_adv_i, panel_reset_used_i, panel_auto_i,
                 channels_i, panel_mem_i, panel_track_i};
    r_next.s2 = r_reg.s1;
    r_next.done_d = done_s;
    r_next.dgo = 1'b0;
    r_next.mre = 1'b0;
    r_next.mwe = 1'b0;
    r_next.ack = 1'b0;

    // wishbone slave, one answer per request
    if (wb_cyc_i && wb_stb_i && !r_reg.ack) begin
      r_next.ack = 1'b1;
      case (wb_adr_i)
        `OFS_CTRL: begin
          if (wb_we_i && wb_sel_i[0]) begin
            r_next.en = wb_dat_i[`CTRL_EN_BIT];
          end
          r_next.rdat = {31'h0, r_reg.en};
        end
        `OFS_STATUS: begin
          // writing one clears the request
          if (wb_we_i && wb_sel_i[0] && wb_dat_i[`STAT_SRQ_BIT]) begin
            r_next.srq = 1'b0;
          end
          r_next.rdat = {13'h0, r_reg.st, 4'h0, r_reg.mode, r_reg.dtrk,
                         2'h0, r_reg.pend, r_reg.srq};
        end
        `OFS_ADDR: r_next.rdat = 32'(r_reg.addr);
        default: r_next.rdat = 32'h0; // unmapped reads zero
      endcase
    end

    // disk end raises request; set beats clear
    if (done_s && !r_reg.done_d && r_reg.pend) begin
      r_next.pend = 1'b0;
      r_next.srq = 1'b1;
    end

    // talker drain, only while addressed
    if (r_reg.dv && dout_ready_i) begin
      r_next.dv = 1'b0;
    end
    if (!r_next.dv && r_reg.txn != 3'h0 && talk_i) begin
      r_next.dout = r_reg.tx[39:32];
      r_next.dv = 1'b1;
      r_next.tx = {r_reg.tx[31:0], 8'h00};
      r_next.txn = r_reg.txn - 3'h1;
    end

    case (r_reg.st)
      S_IDLE: begin
        if (din_valid_i && r_reg.rdy) begin
          b = din_data_i;
          n = 4'(b - `CH_ZERO);
          r_next.ld_asc = 1'b0;
          r_next.ld_bin = 1'b0;
          case (r_reg.mode)
            ASCII_AUTO_ADVANCE, ASCII_LOAD_ADDR: begin
              // delimiters between fields are skipped
              if (b != `CH_CR && b != `CH_LF) begin
                if (r_reg.fcnt == 3'h0) begin
                  // sign first, space counts as plus
                  r_next.neg = (b == `CH_MINUS);
                  r_next.acc = 16'h0000;
                  r_next.fcnt = 3'h1;
                end else begin
                  mag = 16'({r_reg.acc[12:0], 3'h0} + {r_reg.acc[14:0], 1'b0}
                            + {12'h000, n});
                  r_next.acc = mag;
                  r_next.fcnt = r_reg.fcnt + 3'h1;
                  if (r_reg.fcnt == `ASCII_LEN - 3'h1) begin
                    fin = 1'b1;
                    v = r_reg.neg ? 16'(-mag) : mag;
                  end
                end
              end
            end
            BINARY_AUTO_ADVANCE, BINARY_LOAD_ADDR: begin
              if (r_reg.fcnt == 3'h0) begin
                r_next.acc = {b, 8'h00};
                r_next.fcnt = 3'h1;
              end else begin
                // high byte first, joined as 16 bits
                fin = 1'b1;
                v = {r_reg.acc[15:8], b};
              end
            end
            NORM_BOTH, NORM_STANDARD, NORM_RESET: begin
              if (r_reg.mode != NORM_RESET) begin
                r_next.nstd[idx] = b;
              end
              if (r_reg.mode != NORM_STANDARD) begin
                r_next.nrst[idx] = b;
              end
              {r_next.nset, r_next.npos} = nstep(r_reg.nset, r_reg.npos);
            end
            default: ; // status takes no input
          endcase
          if (fin) begin
            r_next.fcnt = 3'h0;
            if (!r_reg.mode[0]) begin
              r_next.mwe = 1'b1;
              r_next.maddr = r_reg.addr;
              r_next.mwd = sat(v);
              r_next.addr = r_reg.addr + 1'b1;
            end else begin
              r_next.addr = v[ADDR_W-1:0];
              r_next.maddr = v[ADDR_W-1:0];
              r_next.mre = 1'b1;
              r_next.st = S_RD;
            end
          end
        end else if (talk_i && r_reg.txn == 3'h0 && !r_reg.dv) begin
          case (r_reg.mode)
            ASCII_AUTO_ADVANCE, BINARY_AUTO_ADVANCE: begin
              r_next.mre = 1'b1;
              r_next.maddr = r_reg.addr;
              r_next.addr = r_reg.addr + 1'b1;
              r_next.st = S_RD;
            end
            STATUS_REPORT: begin
              r_next.tx = {`CH_ZERO + {4'h0, trk_s}, `CH_ZERO + {5'h00, mem_s}, 24'h0};
              r_next.txn = `BIN_LEN;
            end
            NORM_BOTH, NORM_STANDARD, NORM_RESET: begin
              // reset kind mirrors standard until used
              nb = (r_reg.mode == NORM_RESET && rstu_s) ? r_reg.nrst[idx]
                                                         : r_reg.nstd[idx];
              if (r_reg.npos == `POS_HFLAG && ext_s) begin
                nb = `CH_ZERO;
              end
              if (r_reg.npos == `POS_MFRAC) begin
                nb = `CH_ZERO + {4'h0, frac};
              end
              if (r_reg.mode != NORM_RESET || !rstu_s) begin
                if (r_reg.npos == `POS_VZSIGN) begin
                  nb = `CH_SPACE;
                end else if (r_reg.npos > `POS_VZSIGN && r_reg.npos <= `POS_VZLAST) begin
                  nb = `CH_ZERO;
                end
              end
              r_next.tx = {nb, 32'h0};
              r_next.txn = 3'h1;
              {r_next.nset, r_next.npos} = nstep(r_reg.nset, r_reg.npos);
            end
            default: ; // load modes wait for an address
          endcase
        end
      end
      S_RD: begin
        // reply never leaves the sample range
        v = sat(mem_rdata_i);
        if (r_reg.mre) begin
          // memory answers the cycle after its strobe, so the strobe cycle only waits
          r_next.st = S_RD;
        end else if (r_reg.mode[1]) begin
          r_next.tx = {v, 24'h0};
          r_next.txn = `BIN_LEN;
          r_next.st = S_IDLE;
        end else begin
          r_next.tx = {(v[15] ? `CH_MINUS : `CH_SPACE), 32'h0};
          r_next.cv = v[15] ? 12'(-v) : v[11:0];
          r_next.ck = 2'h0;
          r_next.dig = 4'h0;
          r_next.st = S_CONV;
        end
      end
      S_CONV: begin
        // slow but small: one subtraction per cycle
        if (r_reg.ck == 2'h3) begin
          r_next.tx[31:0] = {r_reg.tx[23:0], `CH_ZERO + 8'(r_reg.cv)};
          r_next.txn = `ASCII_LEN;
          r_next.st = S_IDLE;
        end else if (r_reg.cv >= pw(r_reg.ck)) begin
          r_next.cv = r_reg.cv - pw(r_reg.ck);
          r_next.dig = r_reg.dig + 4'h1;
        end else begin
          r_next.tx[31:0] = {r_reg.tx[23:0], `CH_ZERO + {4'h0, r_reg.dig}};
          r_next.ck = r_reg.ck + 2'h1;
          r_next.dig = 4'h0;
        end
      end
      default: r_next.st = S_IDLE;
    endcase

    // command decoder, letter then digit
    if (cmd_valid_i && r_reg.en) begin
      b = cmd_data_i;
      n = 4'(b - `CH_ZERO);
      if (!r_reg.lead_v) begin
        r_next.lead = b;
        r_next.lead_v = (b == `CH_H) || (b == `CH_R) || (b == `CH_S)
                     || (b == `CH_T) || (b == `CH_D) || (b == `CH_N);
      end else begin
        r_next.lead_v = 1'b0;
        // digits outside zero to eight dropped
        if (b >= `CH_ZERO && b <= `CH_EIGHT) begin
          case (r_reg.lead)
            `CH_H: begin
              if (n == `AUTO_ARG && auto_s) begin
                r_next.dgo = 1'b1;
                r_next.dop = OP_AUTO;
                r_next.pend = 1'b1;
                r_next.ld_asc = 1'b0;
                r_next.ld_bin = 1'b0;
              end
            end
            `CH_R, `CH_S: begin
              r_next.dgo = 1'b1;
              r_next.dop = (r_reg.lead == `CH_R) ? OP_RECALL : OP_STORE;
              r_next.dtrk = (n == 4'h0) ? trk_s : n;
              r_next.pend = 1'b1;
              r_next.ld_asc = 1'b0;
              r_next.ld_bin = 1'b0;
            end
            `CH_T: begin
              // zero leaves track, no request armed
              if (n != 4'h0) begin
                r_next.dgo = 1'b1;
                r_next.dop = OP_SEEK;
                r_next.dtrk = n;
              end
              r_next.ld_asc = 1'b0;
              r_next.ld_bin = 1'b0;
            end
            `CH_D: begin
              if (n <= 4'h4) begin
                r_next.mode = mode_t'(n);
                // load then advance starts at zero
                if ((n == 4'h0 && r_reg.ld_asc) || (n == 4'h2 && r_reg.ld_bin)) begin
                  r_next.addr = '0;
                end
                r_next.ld_asc = (n == 4'h1);
                r_next.ld_bin = (n == 4'h3);
                r_next.fcnt = 3'h0;
                r_next.txn = 3'h0;
                r_next.st = S_IDLE;
              end
            end
            `CH_N: begin
              if (n <= 4'h2) begin
                r_next.mode = mode_t'({1'b1, n[2:0]});
                r_next.nset = 3'h0;
                r_next.npos = 5'h00;
                r_next.txn = 3'h0;
                r_next.st = S_IDLE;
                r_next.ld_asc = 1'b0;
                r_next.ld_bin = 1'b0;
              end
            end
            default: ;
          endcase
        end
      end
    end
    r_next.rdy = (r_next.st == S_IDLE);
  end

  // ************
  // state register
  // ************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
      r_reg.st <= S_IDLE;
      r_reg.en <= `CTRL_RST;
      r_reg.rdy <= 1'b1;
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state register
  assign wb_dat_o = r_reg.rdat;
  assign wb_ack_o = r_reg.ack;
  assign din_ready_o = r_reg.rdy;
  assign dout_valid_o = r_reg.dv;
  assign dout_data_o = r_reg.dout;
  assign mem_addr_o = r_reg.maddr;
  assign mem_rd_o = r_reg.mre;
  assign mem_wr_o = r_reg.mwe;
  assign mem_wdata_o = r_reg.mwd;
  assign disk_go_o = r_reg.dgo;
  assign disk_op_o = r_reg.dop;
  assign disk_track_o = r_reg.dtrk;
  assign srq_o = r_reg.srq;

  // ************
  // assertions
  // ************
  logic cmd_exec;
  assign cmd_exec = cmd_valid_i && r_reg.en && r_reg.lead_v;
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);

  sequence s_fetch_ascii;
    r_reg.st == S_RD && r_reg.mode[3:1] == 3'h0 && !r_reg.mre;
  endsequence
  sequence s_five_chars;
    r_reg.st == S_CONV ##[1:40] r_reg.txn == `ASCII_LEN;
  endsequence

  a_srq_on_done: assert property (done_s && !r_reg.done_d && r_reg.pend |=> srq_o)
    else $error("disk end gave no request");
  a_auto_gate: assert property (disk_go_o && disk_op_o == OP_AUTO |-> $past(auto_s))
    else $error("autocycle without panel switch");
  a_seek_quiet: assert property (disk_go_o && disk_op_o == OP_SEEK |->
      disk_track_o != 4'h0 && disk_track_o <= `TRACK_MAX && !$rose(r_reg.pend))
    else $error("bad track select");
  a_ascii_zero: assert property (cmd_exec && r_reg.lead == `CH_D
      && cmd_data_i == `CH_ZERO && r_reg.ld_asc |=> r_reg.addr == '0)
    else $error("ascii counter not cleared");
  a_binary_zero: assert property (cmd_exec && r_reg.lead == `CH_D
      && cmd_data_i == `CH_ZERO + 8'h02 && r_reg.ld_bin |=> r_reg.addr == '0)
    else $error("binary counter not cleared");
  a_ascii_field: assert property (s_fetch_ascii |=> s_five_chars)
    else $error("ascii reply not five chars");
  a_binary_pair: assert property (r_reg.st == S_RD && r_reg.mode[1] && !cmd_valid_i && !mem_rd_o
      |=> r_reg.txn == `BIN_LEN && r_reg.tx[39:24] == sat($past(mem_rdata_i)))
    else $error("binary reply wrong");
  a_write_range: assert property (mem_wr_o |-> $signed(mem_wdata_o) <= $signed(`DATA_MAX)
      && $signed(mem_wdata_o) >= $signed(`DATA_MIN))
    else $error("sample out of range");
  a_status_pair: assert property (r_reg.mode == STATUS_REPORT && r_reg.st == S_IDLE
      && talk_i && r_reg.txn == 3'h0 && !r_reg.dv && !cmd_valid_i && !din_valid_i
      |=> r_reg.txn == `BIN_LEN && r_reg.tx[39:32] == `CH_ZERO + {4'h0, $past(trk_s)})
    else $error("status reply wrong");
  a_bad_digit: assert property (cmd_exec && cmd_data_i > `CH_EIGHT
      |=> !disk_go_o && $stable(r_reg.mode))
    else $error("bad command acted on");
endmodule : scope_bus_command_set

// ==== tb/scope_far_model.sv ====
// far-side stand-in: waveform memory and disk recorder
// assumes the interpreter's clock and its registered strobes
`timescale 1ns/10ps
module scope_far_model (
  input wire logic clk_i,
  input wire logic [11:0] mem_addr_i,
  input wire logic mem_rd_i,
  output logic [15:0] mem_rdata_o,
  input wire logic disk_go_i,
  output logic disk_done_o
);
  logic [3:0] busy_reg = 4'h0; // disk job countdown
  logic [15:0] rd_reg = 16'h0; // memory output register
  logic done_reg = 1'b0; // disk job finished
  assign mem_rdata_o = rd_reg;
  assign disk_done_o = done_reg;
  // value for address, valid the cycle after the strobe; inverted each cycle after that
  always_ff @(posedge clk_i) begin
    rd_reg <= mem_rd_i ? {4'h0, mem_addr_i} : ~rd_reg;
  end
  // a job takes a while, so the done edge never meets the go pulse
  always_ff @(posedge clk_i) begin
    if (disk_go_i) begin
      busy_reg <= 4'hf;
      done_reg <= 1'b0;
    end else if (busy_reg != 4'h0) begin
      busy_reg <= busy_reg - 4'h1;
      done_reg <= (busy_reg == 4'h1);
    end
  end
endmodule : scope_far_model

// ==== tb/scope_bus_command_set_tb_top.sv ====
// bench for the bus command interpreter
// assumes the far-side model beside it
`timescale 1ns/10ps
module scope_bus_command_set_tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0, ptrack = 4'h3, trk;
  logic [31:0] wdat = 32'h0, rdat;
  logic ack, cv = 1'b0, dv = 1'b0, drdy, talk = 1'b0, ov, ordy = 1'b0, rd, wr, go, srq;
  logic [7:0] cd = 8'h0, dd = 8'h0, od;
  logic [11:0] maddr;
  logic [15:0] wd, rdd;
  logic [2:0] pmem = 3'h5;
  logic [1:0] op;
  logic pauto = 1'b0, ext = 1'b0; // panel autocycle switch, external advance
  logic done;
  int bad_count = 0, samples_checked = 0, cyc_n = 0;
  scope_bus_command_set dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .cmd_valid_i(cv), .cmd_data_i(cd), .din_valid_i(dv),
    .din_data_i(dd), .din_ready_o(drdy), .talk_i(talk), .dout_valid_o(ov), .dout_data_o(od),
    .dout_ready_i(ordy), .mem_addr_o(maddr), .mem_rd_o(rd), .mem_wr_o(wr), .mem_wdata_o(wd),
    .mem_rdata_i(rdd), .panel_track_i(ptrack), .panel_mem_i(pmem), .panel_auto_i(pauto),
    .panel_reset_used_i(1'b0), .ext_adv_i(ext), .channels_i(2'h1), .disk_done_i(done),
    .disk_go_o(go), .disk_op_o(op), .disk_track_o(trk), .srq_o(srq));
  scope_far_model far (.clk_i(clk_i), .mem_addr_i(maddr), .mem_rd_i(rd), .mem_rdata_o(rdd),
    .disk_go_i(go), .disk_done_o(done));
  // 50 MHz clock
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // verdict and end of run
  task automatic report_and_stop();
    if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // classic cycle, held until ack
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
    input logic [31:0] exp);
    @(posedge clk_i) {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    if (!w) chk(rdat, exp);
    {cyc, stb} <= 2'b00;
  endtask : wb
  task automatic cmd2(input logic [7:0] a, input logic [7:0] b);
    @(posedge clk_i) {cv, cd} <= {1'b1, a};
    @(posedge clk_i) cd <= b;
    @(posedge clk_i) cv <= 1'b0;
  endtask : cmd2
  task automatic din(input logic [7:0] b);
    @(posedge clk_i) {dv, dd} <= {1'b1, b};
    do @(posedge clk_i); while (drdy !== 1'b1);
    dv <= 1'b0;
  endtask : din
  // wait for a strobe, bounded
  task automatic wait_for(ref logic s, input int n);
    while (s !== 1'b1 && n > 0) begin
      @(posedge clk_i);
      n--;
    end
    chk(s, 1'b1);
  endtask : wait_for
  task automatic t_reset();
    wb(1'b0, 4'h4, 32'h0, 32'h0001_0000);
    wb(1'b0, 4'h8, 32'h0, 32'h0);
    wb(1'b0, 4'hc, 32'h0, 32'h0);
    wb(1'b0, 4'h0, 32'h0, 32'h1);
  endtask : t_reset
  // disk command: go with op and track, then a request once the job ends
  task automatic disk(input logic [7:0] a, input logic [7:0] b, input logic [5:0] exp);
    cmd2(a, b);
    wait_for(go, 5);
    chk({op, trk}, exp);
    wait_for(srq, 40);
    wb(1'b1, 4'h4, 32'h1, 32'h0);
    @(posedge clk_i) chk(srq, 1'b0);
  endtask : disk
  // track differs from the panel's, then zero takes the panel's
  task automatic t_recall();
    disk(8'h52, 8'h35, 6'h05);
    disk(8'h53, 8'h30, 6'h13);
  endtask : t_recall
  // switch on, autocycle runs and ends in a request
  task automatic t_auto();
    pauto <= 1'b1;
    repeat (3) @(posedge clk_i);
    disk(8'h48, 8'h33, 6'h37);
  endtask : t_auto
  // select zero, autocycle with switch off, unknown code: all silent
  task automatic t_quiet();
    int n = 0;
    cmd2(8'h54, 8'h37);
    wait_for(go, 5);
    chk({op, trk}, 6'h27);
    fork
      begin
        cmd2(8'h54, 8'h30);
        cmd2(8'h48, 8'h33);
        cmd2(8'h58, 8'h31);
        cmd2(8'h52, 8'h39);
        repeat (40) @(posedge clk_i);
      end
      repeat (48) @(posedge clk_i) n += int'(go);
    join
    chk({n[7:0], srq}, 9'h0);
  endtask : t_quiet
  // binary writes move the counter, load then advance restarts it, load reads back
  task automatic t_binary();
    cmd2(8'h44, 8'h32);
    din(8'h00);
    din(8'hea);
    wait_for(wr, 5);
    chk({maddr, wd}, {12'h0, 16'h00ea});
    din(8'hff);
    din(8'h16);
    wait_for(wr, 5);
    chk({maddr, wd}, {12'h1, 16'hff16});
    cmd2(8'h44, 8'h33);
    cmd2(8'h44, 8'h32);
    din(8'h7f);
    din(8'hff);
    wait_for(wr, 5);
    chk({maddr, wd}, {12'h0, 16'h07ff});
    cmd2(8'h44, 8'h33);
    din(8'h0a);
    din(8'hbc);
    talk <= 1'b1;
    rx(8'h07);
    rx(8'hff);
    talk <= 1'b0;
  endtask : t_binary
  // ascii address in, clamped five-character value out, then load restart
  task automatic t_ascii();
    logic [7:0] sa [5] = '{8'h20, 8'h34, 8'h30, 8'h38, 8'h35};
    logic [7:0] ra [5] = '{8'h20, 8'h32, 8'h30, 8'h34, 8'h37};
    cmd2(8'h44, 8'h31);
    foreach (sa[i]) din(sa[i]);
    talk <= 1'b1;
    foreach (ra[i]) rx(ra[i]);
    talk <= 1'b0;
    cmd2(8'h44, 8'h31);
    cmd2(8'h44, 8'h30);
    wb(1'b0, 4'h8, 32'h0, 32'h0);
  endtask : t_ascii
  // standard write, reset kind read back as standard, forced fields
  task automatic t_norm();
    ext <= 1'b1;
    cmd2(8'h4e, 8'h31);
    din(8'h41);
    cmd2(8'h4e, 8'h32);
    talk <= 1'b1;
    rx(8'h41);
    rx(8'h30);
    rx(8'h32);
    rx(8'h20);
    rx(8'h30);
    talk <= 1'b0;
  endtask : t_norm
  task automatic rx(input logic [7:0] exp);
    @(posedge clk_i);
    wait_for(ov, 60);
    chk(od, exp);
    ordy <= 1'b1;
    @(posedge clk_i) ordy <= 1'b0;
  endtask : rx
  task automatic t_status();
    cmd2(8'h44, 8'h34);
    @(posedge clk_i) talk <= 1'b1;
    rx(8'h33);
    rx(8'h35);
    talk <= 1'b0;
  endtask : t_status
  // hang guard
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_recall();
    t_quiet();
    t_auto();
    t_binary();
    t_ascii();
    t_status();
    t_norm();
    report_and_stop();
  end
endmodule : scope_bus_command_set_tb_top
